//--- common/adf_pkg.sv
// package: register map, field layout and constants of the decimation filter
`default_nettype none
package adf_pkg;
  // ----------------------------------------------------------------------
  // modulator clock
  // ----------------------------------------------------------------------
  localparam int unsigned MOD_DIV      = 16;
  localparam logic [3:0]  MOD_DIV_LAST = 4'(MOD_DIV - 1);
  // ----------------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------------
  localparam logic [11:0] OFF_RATE_CFG = 12'h004;
  localparam logic [11:0] OFF_STATUS   = 12'h008;
  localparam logic [11:0] OFF_DATA     = 12'h00c;
  localparam int          CODE_LSB     = 0;
  localparam int          CODE_W       = 4;
  localparam int          FILT_BIT     = 4;
  localparam int          CLK_SEL_BIT  = 5;
  localparam int          DRDY_BIT     = 0;
  localparam logic [7:0]  RATE_CFG_RST = 8'h14;
  localparam logic [1:0]  RESP_OKAY    = 2'h0;
  localparam logic [1:0]  RESP_SLVERR  = 2'h2;
  // ----------------------------------------------------------------------
  // oversampling ratio per rate code
  // ----------------------------------------------------------------------
  localparam int OSR_W = 17;
  typedef logic [OSR_W-1:0] adf_osr_t;
  typedef logic [CODE_W-1:0] adf_code_t;
  function automatic adf_osr_t adf_osr(input adf_code_t code);
    case (code)
      4'h0:    adf_osr = 17'h19000;
      4'h1:    adf_osr = 17'h0c800;
      4'h2:    adf_osr = 17'h06400;
      4'h3:    adf_osr = 17'h03c00;
      4'h4:    adf_osr = 17'h03200;
      4'h5:    adf_osr = 17'h01400;
      4'h6:    adf_osr = 17'h010a8;
      4'h7:    adf_osr = 17'h00a00;
      4'h8:    adf_osr = 17'h00500;
      4'h9:    adf_osr = 17'h00280;
      4'ha:    adf_osr = 17'h00140;
      4'hb:    adf_osr = 17'h00100;
      4'hc:    adf_osr = 17'h00080;
      default: adf_osr = 17'h00040;
    endcase
  endfunction : adf_osr
endpackage : adf_pkg
`default_nettype wire

//--- common/adf_flt_if.sv
// interface: control and result between sequencer and third_order_sinc_path path
`default_nettype none
interface adf_flt_if #(parameter int ACC_W = 52);
  logic             tick;
  logic             bit_in;
  logic             restart;
  logic             dump;
  logic [ACC_W-1:0] result;
  logic             valid;
  modport ctl (output tick, bit_in, restart, dump, input result, valid);
  modport flt (input tick, bit_in, restart, dump, output result, valid);
endinterface : adf_flt_if
`default_nettype wire

//--- logic/adf_third_order_sinc_path.sv
// module: third order sinc decimator, integrators and combs
`default_nettype none
module adf_third_order_sinc_path #(
  parameter int ACC_W = 52
) (
  input  wire logic aclk,
  input  wire logic aresetn,
  adf_flt_if.flt    f
);
  // ----------------------------------------------------------------------
  // integrators at the modulator rate
  // ----------------------------------------------------------------------
  logic [ACC_W-1:0] i1_r, i2_r, i3_r;
  logic [ACC_W-1:0] d1_r, d2_r, d3_r;
  logic [ACC_W-1:0] c1, c2, c3;
  logic [ACC_W-1:0] res_r;
  logic             val_r;

  always_ff @(posedge aclk) begin
    if (!aresetn || f.restart) begin
      i1_r <= '0;
      i2_r <= '0;
      i3_r <= '0;
    end else if (f.tick) begin
      i1_r <= i1_r + ACC_W'(f.bit_in);
      i2_r <= i2_r + i1_r;
      i3_r <= i3_r + i2_r;
    end
  end

  // ----------------------------------------------------------------------
  // combs at the output rate
  // ----------------------------------------------------------------------
  always_comb begin
    c1 = i3_r - d1_r;
    c2 = c1 - d2_r;
    c3 = c2 - d3_r;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || f.restart) begin
      d1_r  <= '0;
      d2_r  <= '0;
      d3_r  <= '0;
      res_r <= '0;
      val_r <= 1'b0;
    end else begin
      val_r <= f.dump;
      if (f.dump) begin
        d1_r  <= i3_r;
        d2_r  <= c1;
        d3_r  <= c2;
        res_r <= c3;
      end
    end
  end

  assign f.result = res_r;
  assign f.valid  = val_r;
endmodule : adf_third_order_sinc_path
`default_nettype wire

//--- logic/adf_top.sv
// module: decimation filter with modulator clock and axi4-lite registers
//
// Chosen here: the AXI4-Lite slave port.
`default_nettype none
module adf_top #(
  parameter int ACC_W = 52
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        mod_bit,
  output logic             mod_clk,
  output logic             clk_src_ext,
  output logic [31:0]      conv_data,
  output logic             conv_valid
);
  // ----------------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------------
  adf_flt_if #(.ACC_W(ACC_W)) flt ();

  logic [3:0]          div_cnt_r;
  logic                mod_clk_r, tick_r, bit_r;
  logic [7:0]          cfg_r;
  logic                restart_r, dump_r;
  adf_pkg::adf_osr_t   osr, conv_cnt_r, ll_acc_r, ll_res_r;
  logic                ll_valid_r, valid_r, drdy_r;
  logic [31:0]         data_r, sinc_word;
  logic                awready_r, wready_r, bvalid_r;
  logic [11:0]         awaddr_r;
  logic [31:0]         wdata_r;
  logic                wstrb0_r;
  logic [1:0]          bresp_r;
  logic                arready_r, rvalid_r;
  logic [31:0]         rdata_r;
  logic [1:0]          rresp_r;
  logic                wr_go, rd_go, cfg_wr, data_rd;

  // ----------------------------------------------------------------------
  // modulator clock divider
  // ----------------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_cnt_r <= 4'h0;
      mod_clk_r <= 1'b0;
      tick_r    <= 1'b0;
      bit_r     <= 1'b0;
    end else begin
      div_cnt_r <= div_cnt_r + 4'h1;
      mod_clk_r <= div_cnt_r[3];
      tick_r    <= (div_cnt_r == adf_pkg::MOD_DIV_LAST);
      if (div_cnt_r == adf_pkg::MOD_DIV_LAST)
        bit_r <= mod_bit;
    end
  end

  // ----------------------------------------------------------------------
  // rate lookup and conversion counter
  // ----------------------------------------------------------------------
  // code alone picks the ratio, filter bit is not looked at
  assign osr = adf_pkg::adf_osr(cfg_r[adf_pkg::CODE_LSB +: adf_pkg::CODE_W]);

  always_ff @(posedge aclk) begin
    if (!aresetn || restart_r) begin
      conv_cnt_r <= '0;
      dump_r     <= 1'b0;
    end else begin
      dump_r <= tick_r && (conv_cnt_r == osr - 17'h1);
      if (tick_r)
        conv_cnt_r <= (conv_cnt_r == osr - 17'h1) ? '0
                                                  : conv_cnt_r + 17'h1;
    end
  end

  // ----------------------------------------------------------------------
  // low latency path: integrate and dump over one conversion
  // ----------------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn || restart_r) begin
      ll_acc_r   <= '0;
      ll_res_r   <= '0;
      ll_valid_r <= 1'b0;
    end else begin
      ll_valid_r <= dump_r;
      if (dump_r) begin
        ll_res_r <= ll_acc_r;
        ll_acc_r <= '0;
      end else if (tick_r) begin
        ll_acc_r <= ll_acc_r + adf_pkg::OSR_W'(bit_r);
      end
    end
  end

  // ----------------------------------------------------------------------
  // third_order_sinc_path path
  // ----------------------------------------------------------------------
  assign flt.tick    = tick_r;
  assign flt.bit_in  = bit_r;
  assign flt.restart = restart_r;
  assign flt.dump    = dump_r;
  assign sinc_word   = flt.result[ACC_W-1 -: 32];

  adf_third_order_sinc_path #(.ACC_W(ACC_W)) u_third_order_sinc_path (
    .aclk    (aclk),
    .aresetn (aresetn),
    .f       (flt.flt)
  );

  // ----------------------------------------------------------------------
  // output select and data ready
  // ----------------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn || restart_r) begin
      data_r  <= '0;
      valid_r <= 1'b0;
    end else begin
      valid_r <= ll_valid_r;
      if (ll_valid_r && !cfg_r[adf_pkg::FILT_BIT])
        data_r <= 32'(ll_res_r);
      else if (flt.valid && cfg_r[adf_pkg::FILT_BIT])
        data_r <= sinc_word;
    end
  end

  // a new result wins over a read that clears the flag
  always_ff @(posedge aclk) begin
    if (!aresetn)
      drdy_r <= 1'b0;
    else if (valid_r)
      drdy_r <= 1'b1;
    else if (data_rd)
      drdy_r <= 1'b0;
  end

  // ----------------------------------------------------------------------
  // axi4-lite write channel
  // ----------------------------------------------------------------------
  assign wr_go  = !awready_r && !wready_r && !bvalid_r;
  assign cfg_wr = wr_go && wstrb0_r && (awaddr_r == adf_pkg::OFF_RATE_CFG);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_r <= 1'b1;
      wready_r  <= 1'b1;
      bvalid_r  <= 1'b0;
      bresp_r   <= adf_pkg::RESP_OKAY;
      awaddr_r  <= '0;
      wdata_r   <= '0;
      wstrb0_r  <= 1'b0;
    end else begin
      if (awready_r && s_axi_awvalid) begin
        awready_r <= 1'b0;
        awaddr_r  <= {s_axi_awaddr[11:2], 2'h0};
      end
      if (wready_r && s_axi_wvalid) begin
        wready_r <= 1'b0;
        wdata_r  <= s_axi_wdata;
        wstrb0_r <= s_axi_wstrb[0];
      end
      if (wr_go) begin
        bvalid_r <= 1'b1;
        bresp_r  <= (awaddr_r == adf_pkg::OFF_RATE_CFG) ? adf_pkg::RESP_OKAY
                                                        : adf_pkg::RESP_SLVERR;
      end
      if (bvalid_r && s_axi_bready) begin
        bvalid_r  <= 1'b0;
        awready_r <= 1'b1;
        wready_r  <= 1'b1;
      end
    end
  end

  // rate register; a write with byte 0 strobed restarts the conversion
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg_r       <= adf_pkg::RATE_CFG_RST;
      restart_r   <= 1'b0;
      clk_src_ext <= 1'b0;
    end else begin
      restart_r   <= cfg_wr;
      clk_src_ext <= cfg_r[adf_pkg::CLK_SEL_BIT];
      if (cfg_wr)
        cfg_r <= wdata_r[7:0];
    end
  end

  // ----------------------------------------------------------------------
  // axi4-lite read channel
  // ----------------------------------------------------------------------
  assign rd_go   = arready_r && s_axi_arvalid;
  assign data_rd = rd_go && (s_axi_araddr[11:2] == adf_pkg::OFF_DATA[11:2]);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_r <= 1'b1;
      rvalid_r  <= 1'b0;
      rdata_r   <= '0;
      rresp_r   <= adf_pkg::RESP_OKAY;
    end else begin
      if (rd_go) begin
        arready_r <= 1'b0;
        rvalid_r  <= 1'b1;
        rresp_r   <= adf_pkg::RESP_OKAY;
        case ({s_axi_araddr[11:2], 2'h0})
          adf_pkg::OFF_RATE_CFG: rdata_r <= {24'h0, cfg_r};
          adf_pkg::OFF_STATUS:   rdata_r <= {31'h0, drdy_r};
          adf_pkg::OFF_DATA:     rdata_r <= data_r;
          default: begin
            rdata_r <= '0;
            rresp_r <= adf_pkg::RESP_SLVERR;
          end
        endcase
      end
      if (rvalid_r && s_axi_rready) begin
        rvalid_r  <= 1'b0;
        arready_r <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------------
  assign s_axi_awready = awready_r;
  assign s_axi_wready  = wready_r;
  assign s_axi_bvalid  = bvalid_r;
  assign s_axi_bresp   = bresp_r;
  assign s_axi_arready = arready_r;
  assign s_axi_rvalid  = rvalid_r;
  assign s_axi_rdata   = rdata_r;
  assign s_axi_rresp   = rresp_r;
  assign mod_clk       = mod_clk_r;
  assign conv_data     = data_r;
  assign conv_valid    = valid_r;

  // ----------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------
  property p_tick_period;
    @(posedge aclk) disable iff (!aresetn)
      tick_r |-> ##1 !tick_r [*8] ##1 !tick_r [*7] ##1 tick_r;
  endproperty
  a_tick_period: assert property (p_tick_period)
    else $error("modulator tick not every 16 clocks");
  property p_mod_clk_high;
    @(posedge aclk) disable iff (!aresetn)
      $rose(mod_clk_r) |-> mod_clk_r [*8] ##1 !mod_clk_r;
  endproperty
  a_mod_clk_high: assert property (p_mod_clk_high)
    else $error("modulator clock high phase not 8 clocks");
  property p_dump_at_ratio;
    @(posedge aclk) disable iff (!aresetn || restart_r)
      dump_r |-> $past(tick_r) && $past(conv_cnt_r) == $past(osr) - 17'h1
                 && conv_cnt_r == '0;
  endproperty
  a_dump_at_ratio: assert property (p_dump_at_ratio)
    else $error("decimation not at ratio count");
  property p_cnt_bound;
    @(posedge aclk) disable iff (!aresetn)
      conv_cnt_r < osr || $past(cfg_wr) || restart_r;
  endproperty
  a_cnt_bound: assert property (p_cnt_bound)
    else $error("conversion counter ran past ratio");
  property p_ratio_fast;
    @(posedge aclk) disable iff (!aresetn)
      cfg_r[3:0] == 4'hd |-> osr == 17'h00040;
  endproperty
  a_ratio_fast: assert property (p_ratio_fast)
    else $error("code 1101 ratio is not 64");
  property p_ratio_slow;
    @(posedge aclk) disable iff (!aresetn)
      cfg_r[3:0] == 4'h0 |-> osr == 17'h19000;
  endproperty
  a_ratio_slow: assert property (p_ratio_slow)
    else $error("code 0000 ratio is not 102400");
  property p_ll_select;
    @(posedge aclk) disable iff (!aresetn || restart_r)
      ll_valid_r && !cfg_r[adf_pkg::FILT_BIT] |=>
        valid_r && data_r == 32'($past(ll_res_r));
  endproperty
  a_ll_select: assert property (p_ll_select)
    else $error("low latency result not delivered");
  property p_sinc_select;
    @(posedge aclk) disable iff (!aresetn || restart_r)
      flt.valid && cfg_r[adf_pkg::FILT_BIT] |=>
        valid_r && data_r == $past(sinc_word);
  endproperty
  a_sinc_select: assert property (p_sinc_select)
    else $error("third_order_sinc_path result not delivered");
  property p_drdy_set;
    @(posedge aclk) disable iff (!aresetn)
      valid_r |=> drdy_r;
  endproperty
  a_drdy_set: assert property (p_drdy_set)
    else $error("data ready not set after result");
  property p_clk_sel;
    @(posedge aclk) disable iff (!aresetn)
      ##1 clk_src_ext == $past(cfg_r[adf_pkg::CLK_SEL_BIT]);
  endproperty
  a_clk_sel: assert property (p_clk_sel)
    else $error("clock select output wrong");
endmodule : adf_top
`default_nettype wire

//--- sim/adf_mod_model.sv
// partner model: modulator bitstream source on the modulator clock
`default_nettype none
module adf_mod_model (
  input  wire logic       mod_clk,
  input  wire logic [1:0] mode,
  output logic            mod_bit
);
  timeunit 1ns;
  timeprecision 1ns;
  // --------------------
  // bitstream
  // --------------------
  initial mod_bit = 1'b0;
  // one new bit per modulator clock: 0 zeros, 1 ones, else toggling
  always @(posedge mod_clk) begin
    case (mode)
      2'h0: begin
        mod_bit <= 1'b0;
      end
      2'h1: begin
        mod_bit <= 1'b1;
      end
      default: begin
        mod_bit <= ~mod_bit;
      end
    endcase
  end
endmodule : adf_mod_model
`default_nettype wire

//--- sim/tb.sv
// testbench: registers, modulator clock and both filter paths
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  // --------------------
  // signals
  // --------------------
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [11:0] s_axi_awaddr = '0;
  logic        s_axi_awvalid = 1'b0;
  logic [31:0] s_axi_wdata = '0;
  logic [3:0]  s_axi_wstrb = '0;
  logic        s_axi_wvalid = 1'b0;
  logic        s_axi_bready = 1'b0;
  logic [11:0] s_axi_araddr = '0;
  logic        s_axi_arvalid = 1'b0;
  logic        s_axi_rready = 1'b0;
  logic [1:0]  mode = 2'h0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic        s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata, conv_data;
  logic        mod_bit, mod_clk, clk_src_ext, conv_valid;
  int          n_mismatch = 0;
  int          n_compared = 0;

  adf_top dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .mod_bit, .mod_clk,
    .clk_src_ext, .conv_data, .conv_valid);
  adf_mod_model mdl (.mod_clk, .mode, .mod_bit);

  always #50 aclk = ~aclk;
  // --------------------
  // shared tasks
  // --------------------
  task automatic check(input string name, input logic [31:0] seen,
                       input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected %s: expected %h, seen %h", name, exp, seen);
    end
  endtask : check

  task automatic give_verdict();
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : give_verdict

  task automatic timed_out(input string name);
    n_mismatch++;
    $display("unexpected %s: expected an answer, seen none", name);
    give_verdict();
  endtask : timed_out

  task automatic axi_wr(input logic [11:0] a, input logic [31:0] d,
                        input logic [3:0] s, output logic [1:0] r);
    int i;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (i = 0; i < 100; i++) begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid === 1'b1) break;
    end
    if (i == 100) timed_out("write response");
    s_axi_bready <= 1'b0;
    r = s_axi_bresp;
  endtask : axi_wr

  task automatic axi_rd(input logic [11:0] a, output logic [31:0] d,
                        output logic [1:0] r);
    int i;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (i = 0; i < 100; i++) begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid === 1'b1) break;
    end
    if (i == 100) timed_out("read data");
    s_axi_rready <= 1'b0;
    d = s_axi_rdata;
    r = s_axi_rresp;
  endtask : axi_rd

  task automatic wait_conv(output int cyc);
    cyc = 0;
    do begin
      @(negedge aclk);
      cyc++;
    end while (conv_valid !== 1'b1 && cyc < 40000);
    if (cyc == 40000) timed_out("conversion result");
  endtask : wait_conv

  // write the rate register, let n results pass, return the last interval
  task automatic run_cfg(input logic [7:0] cfg, input logic [1:0] m,
                         input int n, output int cyc);
    logic [1:0] r;
    int k;
    @(posedge aclk);
    mode <= m;
    axi_wr(adf_pkg::OFF_RATE_CFG, 32'(cfg), 4'hf, r);
    check("rate write bresp", 32'(r), 32'(adf_pkg::RESP_OKAY));
    for (k = 0; k < n; k++) begin
      wait_conv(cyc);
    end
    @(negedge aclk);
  endtask : run_cfg
  // --------------------
  // scenarios
  // --------------------
  task automatic t_reset();
    logic [31:0] d;
    logic [1:0] r;
    check("clk_src_ext at reset", 32'(clk_src_ext), 32'h0);
    check("conv_valid at reset", 32'(conv_valid), 32'h0);
    check("conv_data at reset", conv_data, 32'h0);
    check("mod_clk at reset", 32'(mod_clk), 32'h0);
    axi_rd(adf_pkg::OFF_RATE_CFG, d, r);
    check("rate cfg reset", d, 32'(adf_pkg::RATE_CFG_RST));
    check("rate cfg rresp", 32'(r), 32'(adf_pkg::RESP_OKAY));
  endtask : t_reset

  task automatic t_mod_clk();
    int hi, rises, k;
    logic prev;
    hi = 0;
    rises = 0;
    @(negedge aclk);
    prev = mod_clk;
    for (k = 0; k < 4 * adf_pkg::MOD_DIV; k++) begin
      @(negedge aclk);
      hi += int'(mod_clk === 1'b1);
      rises += int'(mod_clk === 1'b1 && prev === 1'b0);
      prev = mod_clk;
    end
    check("mod_clk high cycles", 32'(hi), 32'(2 * adf_pkg::MOD_DIV));
    check("mod_clk rises", 32'(rises), 32'h4);
  endtask : t_mod_clk

  task automatic t_regs();
    logic [31:0] d;
    logic [1:0] r;
    axi_wr(adf_pkg::OFF_STATUS, 32'h1, 4'hf, r);
    check("status write bresp", 32'(r), 32'(adf_pkg::RESP_SLVERR));
    axi_rd(12'h010, d, r);
    check("unmapped rresp", 32'(r), 32'(adf_pkg::RESP_SLVERR));
    check("unmapped rdata", d, 32'h0);
    axi_wr(adf_pkg::OFF_RATE_CFG, 32'h2d, 4'hf, r);
    axi_wr(adf_pkg::OFF_RATE_CFG, 32'h0d, 4'h0, r);
    check("no strobe bresp", 32'(r), 32'(adf_pkg::RESP_OKAY));
    axi_rd(adf_pkg::OFF_RATE_CFG, d, r);
    check("rate cfg readback", d, 32'h2d);
    check("clk_src_ext set", 32'(clk_src_ext), 32'h1);
    axi_wr(adf_pkg::OFF_RATE_CFG, 32'h10, 4'hf, r);
    axi_rd(adf_pkg::OFF_RATE_CFG, d, r);
    check("slowest code readback", d, 32'h10);
  endtask : t_regs

  task automatic t_ll_rates();
    int cyc, c;
    logic [16:0] osr [4] = '{17'd320, 17'd256, 17'd128, 17'd64};
    for (c = 0; c < 4; c++) begin
      run_cfg(8'(10 + c), 2'h1, 3, cyc);
      check("ll interval", 32'(cyc), 32'(osr[c]) * adf_pkg::MOD_DIV);
      check("ll ones count", conv_data, 32'(osr[c]));
    end
    check("clk_src_ext cleared", 32'(clk_src_ext), 32'h0);
  endtask : t_ll_rates

  task automatic t_ll_alt();
    int cyc;
    logic [31:0] d;
    logic [1:0] r;
    run_cfg(8'h0d, 2'h2, 3, cyc);
    check("ll half ones", conv_data, 32'd32);
    axi_rd(adf_pkg::OFF_STATUS, d, r);
    check("drdy after result", d, 32'h1);
    axi_rd(adf_pkg::OFF_DATA, d, r);
    check("data register", d, 32'd32);
    axi_rd(adf_pkg::OFF_STATUS, d, r);
    check("drdy after data read", d, 32'h0);
  endtask : t_ll_alt

  task automatic t_third_order_sinc_path();
    int cyc;
    run_cfg(8'h1c, 2'h1, 4, cyc);
    check("third_order_sinc_path interval", 32'(cyc), 32'd128 * adf_pkg::MOD_DIV);
    // full scale sum is the ratio cubed, shown from bit 20 upward
    check("third_order_sinc_path value", conv_data, 32'((64'd128 ** 3) >> 20));
  endtask : t_third_order_sinc_path
  // --------------------
  // main sequence
  // --------------------
  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_mod_clk();
    t_regs();
    t_ll_rates();
    t_ll_alt();
    t_third_order_sinc_path();
    give_verdict();
  end
endmodule : tb
`default_nettype wire
